// ### hw/nvc_defs.vh
`ifndef NVC_DEFS_VH
`define NVC_DEFS_VH

`define NVC_NIRQ 32
`define NVC_NEXC 15
`define NVC_PRI_W 3
`define NVC_PRI_LOWEST 3'h7
`define NVC_VEC_FIRST 6'h10
`define NVC_ROM_BASE 32'h00000000
`define NVC_RAM_BASE 32'h20000000
`define NVC_VTBS_RST 32'h00000000
`define NVC_VTBS_RAM_BIT 29
`define NVC_VTBS_OFS_MASK 32'h1FFFFF80
`define NVC_MSP_RST 32'h00000100
`define NVC_PSP_RST 32'h00000080
`define NVC_CTRL_DUAL 0
`define NVC_CTRL_PSP 1
`define NVC_EXC_ACT_LSB 16
`define NVC_PRIO_MASK 32'h77777777
`define NVC_DET_PIRQ_LSB 16
`define NVC_DET_PPRI_LSB 21
`define NVC_DET_PV_BIT 24

`define NVC_A_ACTIVE 8'h00
`define NVC_A_VTBS 8'h04
`define NVC_A_ENABLE 8'h08
`define NVC_A_CTRL 8'h0C
`define NVC_A_EXC 8'h10
`define NVC_A_MSP 8'h14
`define NVC_A_PSP 8'h18
`define NVC_A_STAT 8'h1C
`define NVC_A_PRIO0 8'h20
`define NVC_A_PRIO1 8'h24
`define NVC_A_PRIO2 8'h28
`define NVC_A_PRIO3 8'h2C

`define NVC_RESP_OK 2'h0
`define NVC_RESP_ERR 2'h2

`endif

// ### hw/nvc_stack_ram.v
`timescale 1ns/1ps
// context stack storage, registered read data
module nvc_stack_ram (
  // clock
  input wire clk,
  // write port
  input wire wr_en,
  input wire [5:0] wr_addr,
  input wire [31:0] wr_data,
  // read port
  input wire [5:0] rd_addr,
  output reg [31:0] rd_data
);

  reg [31:0] mem [0:63];

  // no reset on the array: contents are only read after being pushed
  always @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule // nvc_stack_ram

// ### hw/nvc_core.v
// The implementer's own choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "nvc_defs.vh"
module nvc_core (
  // clock and reset
  input wire CLK,
  input wire NRST,
  // axi4-lite write
  input wire [7:0] AWADDR,
  input wire AWVALID,
  output wire AWREADY,
  input wire [31:0] WDATA,
  input wire [3:0] WSTRB,
  input wire WVALID,
  output wire WREADY,
  output wire [1:0] BRESP,
  output wire BVALID,
  input wire BREADY,
  // axi4-lite read
  input wire [7:0] ARADDR,
  input wire ARVALID,
  output wire ARREADY,
  output wire [31:0] RDATA,
  output wire [1:0] RRESP,
  output wire RVALID,
  input wire RREADY,
  // interrupt lines
  input wire [31:0] IRQ,
  // core entry and exit
  output wire INT_REQ,
  output wire [4:0] INT_NUM,
  output wire [31:0] HANDLER_ADDR,
  output wire HANDLER_CMODE,
  input wire ENTRY_ACK,
  input wire EXIT_ACK,
  output wire STACK_BUSY,
  // core context
  input wire [255:0] CORE_CTX,
  output wire RESTORE_VALID,
  output wire [2:0] RESTORE_IDX,
  output wire [31:0] RESTORE_DATA,
  // exceptions
  input wire [14:0] EXC_ACTIVE,
  output wire [14:0] EXC_ENABLE,
  // vector table fetch
  output wire VEC_RD,
  output wire [31:0] VEC_ADDR,
  input wire [31:0] VEC_RDATA
);

  localparam S_RUN = 4'h0;
  localparam S_PUSHC = 4'h1;
  localparam S_PUSHD = 4'h2;
  localparam S_VEC = 4'h3;
  localparam S_VWAIT = 4'h4;
  localparam S_REQ = 4'h5;
  localparam S_POPD = 4'h6;
  localparam S_POPDW = 4'h7;
  localparam S_POPC = 4'h8;
  localparam S_POPCW = 4'h9;

  //////////////////////////////////////////////////////////////////////////////
  // registers

  reg aw_ok_reg, w_ok_reg, bvalid_reg, rvalid_reg;
  reg [7:0] awaddr_reg;
  reg [31:0] wdata_reg, rdata_reg;
  reg [3:0] wstrb_reg;
  reg [1:0] bresp_reg, rresp_reg;
  reg [31:0] vtbs_reg, enable_reg, ctrl_reg, msp_reg, psp_reg;
  reg [14:0] exc_en_reg;
  reg [127:0] prio_reg;
  reg [31:0] pend_reg, active_reg, sync1_reg, sync2_reg, prev_reg;
  reg [3:0] state_reg, depth_reg;
  reg [2:0] cnt_reg, cur_pri_reg, sel_pri_reg;
  reg [4:0] cur_irq_reg, sel_irq_reg;
  reg cur_v_reg, frame_psp_reg, base_psp_reg;
  reg vec_rd_reg;
  reg [31:0] vec_addr_reg, handler_reg;

  //////////////////////////////////////////////////////////////////////////////
  // arbitration

  reg win_v;
  reg [2:0] win_pri;
  reg [4:0] win_irq;
  wire [31:0] cand = pend_reg & enable_reg;
  integer i;

  always @* begin
    win_v = 1'b0;
    win_pri = `NVC_PRI_LOWEST;
    win_irq = 5'h00;
    for (i = 0; i < `NVC_NIRQ; i = i + 1) begin
      // strict compare keeps the lower index on a tie
      if (cand[i] && (!win_v || prio_reg[i*4 +: 3] < win_pri)) begin
        win_v = 1'b1;
        win_pri = prio_reg[i*4 +: 3];
        win_irq = i[4:0];
      end
    end
  end

  // only strictly higher priority preempts; others wait to tail chain
  wire preempt = win_v && (!cur_v_reg || win_pri < cur_pri_reg);

  //////////////////////////////////////////////////////////////////////////////
  // stack access

  wire [31:0] sp_cur = frame_psp_reg ? psp_reg : msp_reg;
  wire [31:0] sp_dec = sp_cur - 32'h00000004;
  wire [31:0] sp_inc = sp_cur + 32'h00000004;
  wire push = (state_reg == S_PUSHC) || (state_reg == S_PUSHD);
  wire pop = (state_reg == S_POPD) || (state_reg == S_POPC);
  wire [7:0] ctx_ofs = {3'h7 - cnt_reg, 5'h00};
  // details word carries the new and the suspended interrupt
  wire [31:0] det_w = {7'h00, cur_v_reg, cur_pri_reg, cur_irq_reg,
                       7'h00, 1'b1, sel_pri_reg, sel_irq_reg};
  wire [31:0] ram_wdata = (state_reg == S_PUSHD) ? det_w : CORE_CTX[ctx_ofs +: 32];
  wire [31:0] ram_rdata;

  nvc_stack_ram u_ram (
    .clk(CLK),
    .wr_en(push),
    .wr_addr(sp_dec[7:2]),
    .wr_data(ram_wdata),
    .rd_addr(sp_cur[7:2]),
    .rd_data(ram_rdata)
  );

  wire p_v = ram_rdata[`NVC_DET_PV_BIT];
  wire [2:0] p_pri = ram_rdata[`NVC_DET_PPRI_LSB +: 3];
  wire [4:0] p_irq = ram_rdata[`NVC_DET_PIRQ_LSB +: 5];
  wire chain = win_v && (!p_v || win_pri < p_pri);
  wire first_psp = (depth_reg == 4'h0) && ctrl_reg[`NVC_CTRL_DUAL] && ctrl_reg[`NVC_CTRL_PSP];

  // rom or ram region plus the programmed offset
  wire [31:0] vt_base = (vtbs_reg[`NVC_VTBS_RAM_BIT] ? `NVC_RAM_BASE : `NVC_ROM_BASE)
                        + (vtbs_reg & `NVC_VTBS_OFS_MASK);

  //////////////////////////////////////////////////////////////////////////////
  // entry and exit sequencer, no instruction takes part

  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      state_reg <= S_RUN;
      cnt_reg <= 3'h0;
      depth_reg <= 4'h0;
      cur_v_reg <= 1'b0;
      cur_pri_reg <= 3'h0;
      cur_irq_reg <= 5'h00;
      sel_pri_reg <= 3'h0;
      sel_irq_reg <= 5'h00;
      frame_psp_reg <= 1'b0;
      base_psp_reg <= 1'b0;
      msp_reg <= `NVC_MSP_RST;
      psp_reg <= `NVC_PSP_RST;
      vec_rd_reg <= 1'b0;
      vec_addr_reg <= 32'h00000000;
      handler_reg <= 32'h00000000;
    end else begin
      vec_rd_reg <= 1'b0;
      if (push) begin
        if (frame_psp_reg) psp_reg <= sp_dec;
        else msp_reg <= sp_dec;
      end
      if (pop) begin
        if (frame_psp_reg) psp_reg <= sp_inc;
        else msp_reg <= sp_inc;
      end
      case (state_reg)
        S_RUN: begin
          if (EXIT_ACK && cur_v_reg) begin
            frame_psp_reg <= (depth_reg == 4'h1) && base_psp_reg;
            state_reg <= S_POPD;
          end else if (preempt) begin
            // first frame may use the process stack, nested ones main
            frame_psp_reg <= first_psp;
            if (depth_reg == 4'h0) base_psp_reg <= first_psp;
            sel_pri_reg <= win_pri;
            sel_irq_reg <= win_irq;
            cnt_reg <= 3'h0;
            state_reg <= S_PUSHC;
          end
        end
        S_PUSHC: begin
          // lr, r12, r3..r0, status word, pc of the interrupted code
          cnt_reg <= cnt_reg + 3'h1;
          if (cnt_reg == 3'h7) begin
            // a later, higher request takes the finished frame
            if (preempt) begin
              sel_pri_reg <= win_pri;
              sel_irq_reg <= win_irq;
            end
            state_reg <= S_PUSHD;
          end
        end
        S_PUSHD: begin
          depth_reg <= depth_reg + 4'h1;
          cur_v_reg <= 1'b1;
          cur_pri_reg <= sel_pri_reg;
          cur_irq_reg <= sel_irq_reg;
          state_reg <= S_VEC;
        end
        S_VEC: begin
          // exception slots come first in the table
          vec_rd_reg <= 1'b1;
          vec_addr_reg <= vt_base + {24'h000000, {1'b0, sel_irq_reg} + `NVC_VEC_FIRST, 2'h0};
          state_reg <= S_VWAIT;
        end
        S_VWAIT: begin
          handler_reg <= VEC_RDATA;
          state_reg <= S_REQ;
        end
        S_REQ: begin
          if (ENTRY_ACK) state_reg <= S_RUN;
        end
        S_POPD: begin
          state_reg <= S_POPDW;
        end
        S_POPDW: begin
          // handler details come off first
          depth_reg <= depth_reg - 4'h1;
          cur_v_reg <= p_v;
          cur_pri_reg <= p_pri;
          cur_irq_reg <= p_irq;
          cnt_reg <= 3'h0;
          if (chain) begin
            // saved context stays; only new details go on
            sel_pri_reg <= win_pri;
            sel_irq_reg <= win_irq;
            state_reg <= S_PUSHD;
          end else begin
            state_reg <= S_POPC;
          end
        end
        S_POPC: begin
          state_reg <= S_POPCW;
        end
        S_POPCW: begin
          // context returns to the core, which resumes where it stopped
          cnt_reg <= cnt_reg + 3'h1;
          state_reg <= (cnt_reg == 3'h7) ? S_RUN : S_POPC;
        end
        default: begin
          state_reg <= S_RUN;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // per-line pending and active flags

  wire ent = (state_reg == S_REQ) && ENTRY_ACK;
  wire ext = (state_reg == S_RUN) && EXIT_ACK && cur_v_reg;

  genvar g;
  generate
    for (g = 0; g < `NVC_NIRQ; g = g + 1) begin : g_line
      wire rise = sync2_reg[g] && !prev_reg[g];
      // a line still high at exit pends again
      wire relevel = ext && (cur_irq_reg == g) && sync2_reg[g];
      wire hit_ent = ent && (sel_irq_reg == g);
      always @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
          sync1_reg[g] <= 1'b0;
          sync2_reg[g] <= 1'b0;
          prev_reg[g] <= 1'b0;
          pend_reg[g] <= 1'b0;
          active_reg[g] <= 1'b0;
        end else begin
          sync1_reg[g] <= IRQ[g];
          sync2_reg[g] <= sync1_reg[g];
          prev_reg[g] <= sync2_reg[g];
          // a new edge beats the clear in the same cycle
          if (rise || relevel) pend_reg[g] <= 1'b1;
          else if (hit_ent) pend_reg[g] <= 1'b0;
          // set on entry, kept while suspended, cleared at exit
          if (hit_ent) active_reg[g] <= 1'b1;
          else if (ext && (cur_irq_reg == g)) active_reg[g] <= 1'b0;
        end
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // axi4-lite slave

  wire do_wr = aw_ok_reg && w_ok_reg && !bvalid_reg;
  wire [31:0] wmask = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}}, {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
  reg wr_map;
  reg [31:0] rd_mux;
  reg rd_map;

  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [31:0] m;
    begin
      merge = (old & ~m) | (nw & m);
    end
  endfunction

  always @* begin
    case (awaddr_reg)
      `NVC_A_ACTIVE, `NVC_A_VTBS, `NVC_A_ENABLE, `NVC_A_CTRL, `NVC_A_EXC,
      `NVC_A_MSP, `NVC_A_PSP, `NVC_A_STAT, `NVC_A_PRIO0, `NVC_A_PRIO1,
      `NVC_A_PRIO2, `NVC_A_PRIO3: wr_map = 1'b1;
      default: wr_map = 1'b0;
    endcase
  end

  always @* begin
    rd_map = 1'b1;
    case (ARADDR)
      `NVC_A_ACTIVE: rd_mux = active_reg;
      `NVC_A_VTBS: rd_mux = vtbs_reg;
      `NVC_A_ENABLE: rd_mux = enable_reg;
      `NVC_A_CTRL: rd_mux = ctrl_reg;
      // exception activity kept apart from line flags
      `NVC_A_EXC: rd_mux = {1'b0, EXC_ACTIVE, 1'b0, exc_en_reg};
      `NVC_A_MSP: rd_mux = msp_reg;
      `NVC_A_PSP: rd_mux = psp_reg;
      `NVC_A_STAT: rd_mux = {15'h0000, state_reg, depth_reg, cur_v_reg, cur_pri_reg, cur_irq_reg};
      `NVC_A_PRIO0: rd_mux = prio_reg[31:0];
      `NVC_A_PRIO1: rd_mux = prio_reg[63:32];
      `NVC_A_PRIO2: rd_mux = prio_reg[95:64];
      `NVC_A_PRIO3: rd_mux = prio_reg[127:96];
      default: begin
        rd_mux = 32'h00000000;
        rd_map = 1'b0;
      end
    endcase
  end

  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      aw_ok_reg <= 1'b0;
      w_ok_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= `NVC_RESP_OK;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= `NVC_RESP_OK;
      vtbs_reg <= `NVC_VTBS_RST;
      enable_reg <= 32'h00000000;
      ctrl_reg <= 32'h00000000;
      exc_en_reg <= 15'h0000;
      prio_reg <= 128'h0;
    end else begin
      if (AWVALID && !aw_ok_reg) begin
        aw_ok_reg <= 1'b1;
        awaddr_reg <= AWADDR;
      end
      if (WVALID && !w_ok_reg) begin
        w_ok_reg <= 1'b1;
        wdata_reg <= WDATA;
        wstrb_reg <= WSTRB;
      end
      if (do_wr) begin
        aw_ok_reg <= 1'b0;
        w_ok_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_map ? `NVC_RESP_OK : `NVC_RESP_ERR;
        case (awaddr_reg)
          `NVC_A_VTBS: vtbs_reg <= merge(vtbs_reg, wdata_reg, wmask);
          `NVC_A_ENABLE: enable_reg <= merge(enable_reg, wdata_reg, wmask);
          `NVC_A_CTRL: ctrl_reg <= merge(ctrl_reg, wdata_reg, wmask) & 32'h00000003;
          `NVC_A_EXC: exc_en_reg <= (exc_en_reg & ~wmask[14:0]) | (wdata_reg[14:0] & wmask[14:0]);
          `NVC_A_PRIO0: prio_reg[31:0] <= merge(prio_reg[31:0], wdata_reg, wmask) & `NVC_PRIO_MASK;
          `NVC_A_PRIO1: prio_reg[63:32] <= merge(prio_reg[63:32], wdata_reg, wmask)
            & `NVC_PRIO_MASK;
          `NVC_A_PRIO2: prio_reg[95:64] <= merge(prio_reg[95:64], wdata_reg, wmask)
            & `NVC_PRIO_MASK;
          `NVC_A_PRIO3: prio_reg[127:96] <= merge(prio_reg[127:96], wdata_reg, wmask)
            & `NVC_PRIO_MASK;
          default: begin
          end
        endcase
      end else if (bvalid_reg && BREADY) begin
        bvalid_reg <= 1'b0;
      end
      if (ARVALID && !rvalid_reg) begin
        rvalid_reg <= 1'b1;
        rdata_reg <= rd_mux;
        rresp_reg <= rd_map ? `NVC_RESP_OK : `NVC_RESP_ERR;
      end else if (rvalid_reg && RREADY) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs

  assign AWREADY = !aw_ok_reg;
  assign WREADY = !w_ok_reg;
  assign BVALID = bvalid_reg;
  assign BRESP = bresp_reg;
  assign ARREADY = !rvalid_reg;
  assign RVALID = rvalid_reg;
  assign RDATA = rdata_reg;
  assign RRESP = rresp_reg;
  assign INT_REQ = (state_reg == S_REQ);
  assign INT_NUM = sel_irq_reg;
  // low bit marks the compressed code mode and is not part of the address
  assign HANDLER_ADDR = {handler_reg[31:1], 1'b0};
  assign HANDLER_CMODE = handler_reg[0];
  assign STACK_BUSY = (state_reg != S_RUN) && (state_reg != S_REQ);
  assign RESTORE_VALID = (state_reg == S_POPCW);
  assign RESTORE_IDX = cnt_reg;
  assign RESTORE_DATA = ram_rdata;
  assign EXC_ENABLE = exc_en_reg;
  assign VEC_RD = vec_rd_reg;
  assign VEC_ADDR = vec_addr_reg;

endmodule // nvc_core

// ### testbench/nvc_core_assertions.sv
`timescale 1ns/1ps
module nvc_chk (
  // clock and reset
  input wire CLK,
  input wire NRST,
  // core link
  input wire INT_REQ,
  input wire [4:0] INT_NUM,
  input wire [31:0] HANDLER_ADDR,
  input wire HANDLER_CMODE,
  input wire ENTRY_ACK,
  input wire STACK_BUSY,
  input wire RESTORE_VALID,
  input wire [2:0] RESTORE_IDX,
  input wire VEC_RD,
  input wire [31:0] VEC_RDATA,
  // read channel
  input wire RVALID,
  input wire RREADY,
  input wire [31:0] RDATA
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);
  property p_req_hold;
    INT_REQ && !ENTRY_ACK |=> INT_REQ && $stable(INT_NUM) && $stable(HANDLER_ADDR);
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("request changed early");
  property p_ack_end;
    INT_REQ && ENTRY_ACK |=> !INT_REQ;
  endproperty
  a_ack_end: assert property (p_ack_end) else $error("request after ack");
  property p_vec_cap;
    VEC_RD |-> ##1 (INT_REQ && HANDLER_ADDR == {$past(VEC_RDATA[31:1]), 1'b0}
      && HANDLER_CMODE == $past(VEC_RDATA[0]));
  endproperty
  a_vec_cap: assert property (p_vec_cap) else $error("vector not passed on");
  property p_busy_first;
    $rose(INT_REQ) |-> $past(STACK_BUSY);
  endproperty
  a_busy_first: assert property (p_busy_first) else $error("request without stacking");
  property p_req_idle;
    INT_REQ |-> !STACK_BUSY;
  endproperty
  a_req_idle: assert property (p_req_idle) else $error("request while busy");
  property p_rst_pulse;
    RESTORE_VALID |=> !RESTORE_VALID;
  endproperty
  a_rst_pulse: assert property (p_rst_pulse) else $error("restore pulse long");
  property p_rst_order;
    RESTORE_VALID && RESTORE_IDX != 3'h7 |-> ##2
      (RESTORE_VALID && RESTORE_IDX == $past(RESTORE_IDX, 2) + 3'h1);
  endproperty
  a_rst_order: assert property (p_rst_order) else $error("restore order");
  property p_rd_hold;
    RVALID && !RREADY |=> RVALID && $stable(RDATA);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
endmodule // nvc_chk
bind nvc_core nvc_chk chk_u (.CLK(CLK), .NRST(NRST), .INT_REQ(INT_REQ), .INT_NUM(INT_NUM),
  .HANDLER_ADDR(HANDLER_ADDR), .HANDLER_CMODE(HANDLER_CMODE), .ENTRY_ACK(ENTRY_ACK),
  .STACK_BUSY(STACK_BUSY), .RESTORE_VALID(RESTORE_VALID), .RESTORE_IDX(RESTORE_IDX),
  .VEC_RD(VEC_RD), .VEC_RDATA(VEC_RDATA), .RVALID(RVALID), .RREADY(RREADY), .RDATA(RDATA));

// ### testbench/nvc_core_model.sv
`timescale 1ns/1ps
module nvc_cm (
  // clock and reset
  input wire clk,
  input wire nrst,
  // entry and exit
  input wire int_req,
  input wire [4:0] int_num,
  input wire [31:0] handler_addr,
  input wire stack_busy,
  output reg entry_ack,
  output reg exit_ack,
  // context
  output wire [255:0] core_ctx,
  input wire restore_valid,
  input wire [2:0] restore_idx,
  input wire [31:0] restore_data,
  // vector table
  input wire vec_rd,
  input wire [31:0] vec_addr,
  output wire [31:0] vec_rdata,
  // bench side
  input wire slow,
  input wire exit_go,
  output reg [7:0] ent_cnt,
  output reg [4:0] ent_num,
  output reg [31:0] ent_haddr,
  output reg [31:0] ent_vaddr,
  output reg [7:0] rst_cnt,
  output reg [7:0] rst_bad
);
  reg [31:0] vword_reg;
  reg [2:0] wait_reg;
  reg exit_pend_reg;
  genvar k;
  generate
    for (k = 0; k < 8; k = k + 1) begin : g_ctx
      assign core_ctx[32*k+:32] = 32'hC0C0C000 | k;
    end
  endgenerate
  // table answers in the strobe cycle; every slot of a moved table is filled
  assign vec_rdata = vec_rd ? {vec_addr[23:0], 8'h01} : vword_reg;
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      entry_ack <= 1'b0;
      exit_ack <= 1'b0;
      vword_reg <= 32'h00000000;
      wait_reg <= 3'h0;
      exit_pend_reg <= 1'b0;
      ent_cnt <= 8'h00;
      ent_num <= 5'h00;
      ent_haddr <= 32'h00000000;
      ent_vaddr <= 32'h00000000;
      rst_cnt <= 8'h00;
      rst_bad <= 8'h00;
    end else begin
      entry_ack <= 1'b0;
      exit_ack <= 1'b0;
      // off-cycle bus wanders so a late sample cannot pass by luck
      vword_reg <= ~vword_reg;
      if (vec_rd) begin
        ent_vaddr <= vec_addr;
      end
      if (int_req && !entry_ack) begin
        if (wait_reg >= (slow ? 3'h6 : 3'h0)) begin
          entry_ack <= 1'b1;
          wait_reg <= 3'h0;
          ent_cnt <= ent_cnt + 8'h01;
          ent_num <= int_num;
          ent_haddr <= handler_addr;
        end else begin
          wait_reg <= wait_reg + 3'h1;
        end
      end
      if (exit_go) begin
        exit_pend_reg <= 1'b1;
      end
      if (exit_pend_reg && !stack_busy && !int_req && !exit_ack) begin
        exit_ack <= 1'b1;
        exit_pend_reg <= 1'b0;
      end
      if (restore_valid) begin
        rst_cnt <= rst_cnt + 8'h01;
        if (restore_data !== (32'hC0C0C000 | restore_idx)) begin
          rst_bad <= rst_bad + 8'h01;
        end
      end
    end
  end
endmodule // nvc_cm

// ### testbench/nested_vectored_interrupt_ctrl_tb_top.sv
`timescale 1ns/1ps
module nested_vectored_interrupt_ctrl_tb_top;
  reg clk = 1'b0;
  reg nrst = 1'b0;
  reg [7:0] awaddr = 8'h00;
  reg [7:0] araddr = 8'h00;
  reg [31:0] wdata = 32'h00000000;
  reg [31:0] irq = 32'h00000000;
  reg [14:0] exc_act = 15'h0000;
  reg awvalid = 1'b0;
  reg wvalid = 1'b0;
  reg bready = 1'b0;
  reg arvalid = 1'b0;
  reg rready = 1'b0;
  reg exit_go = 1'b0;
  reg slow = 1'b0;
  wire awready, wready, bvalid, arready, rvalid, int_req, cmode, eack, xack, busy, rsv, vrd;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata, haddr, rsd, vaddr, vdata, ent_haddr, ent_vaddr;
  wire [4:0] inum, ent_num;
  wire [2:0] ridx;
  wire [255:0] ctx;
  wire [14:0] exc_en;
  wire [7:0] ent_cnt, rst_cnt, rst_bad;
  integer miscompares = 0;
  integer samples_checked = 0;
  reg [7:0] seen = 8'h00;
  reg [7:0] r0 = 8'h00;
  always #20 clk = ~clk;
  nvc_core dut_u (.CLK(clk), .NRST(nrst), .AWADDR(awaddr), .AWVALID(awvalid),
    .AWREADY(awready), .WDATA(wdata), .WSTRB(4'hF), .WVALID(wvalid), .WREADY(wready),
    .BRESP(bresp), .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
    .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
    .IRQ(irq), .INT_REQ(int_req), .INT_NUM(inum), .HANDLER_ADDR(haddr),
    .HANDLER_CMODE(cmode), .ENTRY_ACK(eack), .EXIT_ACK(xack), .STACK_BUSY(busy),
    .CORE_CTX(ctx), .RESTORE_VALID(rsv), .RESTORE_IDX(ridx), .RESTORE_DATA(rsd),
    .EXC_ACTIVE(exc_act), .EXC_ENABLE(exc_en), .VEC_RD(vrd), .VEC_ADDR(vaddr),
    .VEC_RDATA(vdata));
  nvc_cm cm_u (.clk(clk), .nrst(nrst), .int_req(int_req), .int_num(inum),
    .handler_addr(haddr), .stack_busy(busy), .entry_ack(eack), .exit_ack(xack),
    .core_ctx(ctx), .restore_valid(rsv), .restore_idx(ridx), .restore_data(rsd),
    .vec_rd(vrd), .vec_addr(vaddr), .vec_rdata(vdata), .slow(slow), .exit_go(exit_go),
    .ent_cnt(ent_cnt), .ent_num(ent_num), .ent_haddr(ent_haddr), .ent_vaddr(ent_vaddr),
    .rst_cnt(rst_cnt), .rst_bad(rst_bad));
  //////////////////////////////////////////////////////////////////////////////
  task chk(input [31:0] got, input [31:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task conclude;
    begin
      if (miscompares == 0 && samples_checked > 0) begin
        $display("NO MISMATCHES");
      end else begin
        $display("MISMATCHES SEEN");
      end
      $finish;
    end
  endtask
  task axw(input [7:0] a, input [31:0] d, input [1:0] er);
    integer n;
    reg done;
    begin
      n = 0;
      done = 1'b0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!done && n < 50) begin
        @(posedge clk);
        n = n + 1;
        if (awready) awvalid <= 1'b0;
        if (wready) wvalid <= 1'b0;
        if (bvalid) begin
          done = 1'b1;
          bready <= 1'b0;
          chk({30'h0, bresp}, {30'h0, er});
        end
      end
      chk({31'h0, done}, 32'h00000001);
      @(posedge clk);
    end
  endtask
  // rready rises only once data stands, so the slave must hold it a cycle
  task axr(input [7:0] a, input [31:0] exp, input [1:0] er);
    integer n;
    reg done;
    begin
      n = 0;
      done = 1'b0;
      araddr <= a;
      arvalid <= 1'b1;
      while (!done && n < 50) begin
        @(posedge clk);
        n = n + 1;
        if (arready) arvalid <= 1'b0;
        if (rvalid && rready) begin
          done = 1'b1;
          rready <= 1'b0;
          chk(rdata, exp);
          chk({30'h0, rresp}, {30'h0, er});
        end else if (rvalid) begin
          rready <= 1'b1;
        end
      end
      chk({31'h0, done}, 32'h00000001);
    end
  endtask
  // lines stay up long enough to cross the input synchroniser, then drop
  task pulse(input [31:0] m);
    begin
      irq <= irq | m;
      repeat (3) @(posedge clk);
      irq <= irq & ~m;
      @(posedge clk);
    end
  endtask
  task went(input [4:0] num, input [31:0] va);
    integer n;
    begin
      n = 0;
      while (ent_cnt === seen && n < 300) begin
        @(posedge clk);
        n = n + 1;
      end
      chk({31'h0, ent_cnt !== seen}, 32'h00000001);
      seen = ent_cnt;
      chk({27'h0, ent_num}, {27'h0, num});
      chk(ent_vaddr, va);
      chk(ent_haddr, {va[23:0], 8'h00});
      chk({31'h0, cmode}, 32'h00000001);
      @(posedge clk);
    end
  endtask
  task ex;
    integer n;
    begin
      n = 0;
      exit_go <= 1'b1;
      @(posedge clk);
      exit_go <= 1'b0;
      repeat (4) @(posedge clk);
      while (busy && n < 100) begin
        @(posedge clk);
        n = n + 1;
      end
      chk({31'h0, busy}, 32'h00000000);
    end
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    axr(8'h00, 32'h00000000, 2'h0);
    axr(8'h04, 32'h00000000, 2'h0);
    axr(8'h14, 32'h00000100, 2'h0);
    axr(8'h18, 32'h00000080, 2'h0);
    axw(8'h00, 32'hFFFFFFFF, 2'h0);
    axr(8'h00, 32'h00000000, 2'h0);
    axw(8'h30, 32'h00000001, 2'h2);
    axr(8'h30, 32'h00000000, 2'h2);
    axw(8'h08, 32'h00000228, 2'h0);
    axw(8'h20, 32'h00505000, 2'h0);
    axw(8'h24, 32'h00000010, 2'h0);
    pulse(32'h00000028);
    went(5'h03, 32'h0000004C);
    axr(8'h00, 32'h00000008, 2'h0);
    axr(8'h14, 32'h000000DC, 2'h0);
    pulse(32'h00000200);
    went(5'h09, 32'h00000064);
    axr(8'h00, 32'h00000208, 2'h0);
    axr(8'h14, 32'h000000B8, 2'h0);
    r0 = rst_cnt;
    ex;
    chk({24'h0, rst_cnt - r0}, 32'h00000008);
    axr(8'h00, 32'h00000008, 2'h0);
    axr(8'h14, 32'h000000DC, 2'h0);
    r0 = rst_cnt;
    ex;
    went(5'h05, 32'h00000054);
    chk({24'h0, rst_cnt - r0}, 32'h00000000);
    axr(8'h00, 32'h00000020, 2'h0);
    ex;
    axr(8'h14, 32'h00000100, 2'h0);
    axr(8'h00, 32'h00000000, 2'h0);
    axw(8'h0C, 32'h00000003, 2'h0);
    slow <= 1'b1;
    pulse(32'h00000008);
    went(5'h03, 32'h0000004C);
    axr(8'h18, 32'h0000005C, 2'h0);
    axr(8'h14, 32'h00000100, 2'h0);
    pulse(32'h00000200);
    went(5'h09, 32'h00000064);
    axr(8'h14, 32'h000000DC, 2'h0);
    ex;
    ex;
    axr(8'h18, 32'h00000080, 2'h0);
    slow <= 1'b0;
    axw(8'h0C, 32'h00000000, 2'h0);
    axw(8'h04, 32'h20000100, 2'h0);
    axr(8'h04, 32'h20000100, 2'h0);
    irq <= 32'h00000008;
    repeat (6) @(posedge clk);
    irq <= 32'h00000208;
    repeat (3) @(posedge clk);
    irq <= 32'h00000000;
    went(5'h09, 32'h20000164);
    ex;
    went(5'h03, 32'h2000014C);
    ex;
    chk({24'h0, rst_bad}, 32'h00000000);
    exc_act <= 15'h1234;
    axw(8'h10, 32'h00007FFF, 2'h0);
    axr(8'h10, 32'h12347FFF, 2'h0);
    chk({17'h0, exc_en}, 32'h00007FFF);
    axr(8'h00, 32'h00000000, 2'h0);
    conclude;
  end
  // a hang is cut short well past the expected run length
  initial begin
    #2000000;
    miscompares = miscompares + 1;
    conclude;
  end
endmodule // nested_vectored_interrupt_ctrl_tb_top
